// file: hdl/fprsd_host.sv
// host controller driving the boot-sector flash pins
//
// Notes on behaviour
// - sample read data only after tce
// - hold reset low trep; device idles
// - flag operation that reset interrupted, for reissue
// - wait reset_high_to_read after reset before read
`timescale 1ns/1ps
`default_nettype none
module fprsd_host
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [fprsd_pkg::ADDR_W-1:0] req_addr,
   input wire logic [fprsd_pkg::DATA_W-1:0] req_wdata,
   input wire logic reset_req,
   output logic req_ready,
   output logic rsp_valid,
   output logic [fprsd_pkg::DATA_W-1:0] rsp_rdata,
   output logic [fprsd_pkg::SECT_W-1:0] rsp_sector,
   output logic reissue_needed,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic flash_reset_n,
   output logic flash_byte_n,
   output logic [fprsd_pkg::ADDR_W-1:0] flash_addr,
   output logic [fprsd_pkg::DATA_W-1:0] flash_dq_out,
   output logic flash_dq_oe,
   input wire logic [fprsd_pkg::DATA_W-1:0] flash_dq_in,
   input wire logic ready_busy_out
);
   // -------------------------------------------------------------
   // reset release
   // -------------------------------------------------------------
   logic [1:0] rst_sync_ff;
   logic srst_n;

   // async assert, two-flop release
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         rst_sync_ff <= 2'h0;
      else
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
   end
   assign srst_n = rst_sync_ff[1];

   // -------------------------------------------------------------
   // state and sector decode
   // -------------------------------------------------------------
   fprsd_pkg::fprsd_regs_t r_ff;
   fprsd_pkg::fprsd_regs_t nxt_r;
   logic [fprsd_pkg::SECT_W-1:0] req_sector;

   // word mode only, so A19:A12 of the word address picks the sector
   fprsd_sector_dec u_dec
   (
      .mclk(mclk),
      .rst_n(srst_n),
      .upper_addr(req_addr[19:12]),
      .sector(req_sector)
   );

   // next-state logic
   always_comb
   begin
      nxt_r = r_ff;
      nxt_r.rsp_valid = 1'b0;
      // pin inputs cross two flops; only stage two is read
      nxt_r.dq_s1 = flash_dq_in;
      nxt_r.dq_s2 = r_ff.dq_s1;
      nxt_r.rb_s1 = ready_busy_out;
      nxt_r.rb_s2 = r_ff.rb_s1;
      // assertion helpers: access low time, reset low time, time since release
      nxt_r.acc_cnt = (!r_ff.ce_n && !r_ff.oe_n && r_ff.acc_cnt != fprsd_pkg::CNT_MAX) ?
                      r_ff.acc_cnt + fprsd_pkg::CNT_ONE : fprsd_pkg::CNT_ZERO;
      nxt_r.rlow_cnt = (!r_ff.reset_n && r_ff.rlow_cnt != fprsd_pkg::CNT_MAX) ?
                       r_ff.rlow_cnt + fprsd_pkg::CNT_ONE : fprsd_pkg::CNT_ZERO;
      if (!r_ff.reset_n)
         nxt_r.since_cnt = fprsd_pkg::CNT_ZERO;
      else if (r_ff.since_cnt != fprsd_pkg::CNT_MAX)
         nxt_r.since_cnt = r_ff.since_cnt + fprsd_pkg::CNT_ONE;
      if (r_ff.cnt != fprsd_pkg::CNT_MAX)
         nxt_r.cnt = r_ff.cnt + fprsd_pkg::CNT_ONE;
      case (r_ff.state)
         fprsd_pkg::ST_IDLE:
         begin
            if (reset_req)
            begin
               // reset has priority; a busy device loses its operation
               nxt_r.state = fprsd_pkg::ST_RST_LOW;
               nxt_r.reset_n = 1'b0;
               nxt_r.req_ready = 1'b0;
               nxt_r.cnt = fprsd_pkg::CNT_ZERO;
               if (!r_ff.rb_s2)
                  nxt_r.reissue = 1'b1;
            end
            else if (req_valid)
            begin
               nxt_r.req_ready = 1'b0;
               nxt_r.addr = req_addr;
               nxt_r.rsp_sector = req_sector;
               nxt_r.ce_n = 1'b0;
               nxt_r.cnt = fprsd_pkg::CNT_ZERO;
               if (req_write)
               begin
                  // gate stays high so outputs float before we drive
                  nxt_r.we_n = 1'b0;
                  nxt_r.dq_out = req_wdata;
                  nxt_r.dq_oe = 1'b1;
                  nxt_r.reissue = 1'b0;
                  nxt_r.state = fprsd_pkg::ST_WR_PULSE;
               end
               else
               begin
                  nxt_r.oe_n = 1'b0;
                  nxt_r.state = fprsd_pkg::ST_RD_WAIT;
               end
            end
         end
         fprsd_pkg::ST_RD_WAIT:
         begin
            // tce plus the input synchroniser before the sample
            if (r_ff.cnt == fprsd_pkg::TCE_CYC + fprsd_pkg::SYNC_LAT - fprsd_pkg::CNT_ONE)
            begin
               nxt_r.rsp_rdata = r_ff.dq_s2;
               nxt_r.rsp_valid = 1'b1;
               nxt_r.ce_n = 1'b1;
               nxt_r.oe_n = 1'b1;
               nxt_r.req_ready = 1'b1;
               nxt_r.state = fprsd_pkg::ST_IDLE;
            end
         end
         fprsd_pkg::ST_WR_PULSE:
         begin
            if (r_ff.cnt == fprsd_pkg::TWP_CYC - fprsd_pkg::CNT_ONE)
            begin
               nxt_r.we_n = 1'b1;
               nxt_r.ce_n = 1'b1;
               nxt_r.state = fprsd_pkg::ST_WR_HOLD;
            end
         end
         fprsd_pkg::ST_WR_HOLD:
         begin
            // data held one cycle past the strobe edge
            nxt_r.dq_oe = 1'b0;
            nxt_r.req_ready = 1'b1;
            nxt_r.state = fprsd_pkg::ST_IDLE;
         end
         fprsd_pkg::ST_RST_LOW:
         begin
            if (r_ff.cnt == fprsd_pkg::TREP_CYC - fprsd_pkg::CNT_ONE)
            begin
               nxt_r.reset_n = 1'b1;
               nxt_r.cnt = fprsd_pkg::CNT_ZERO;
               nxt_r.state = fprsd_pkg::ST_RST_REC;
            end
         end
         fprsd_pkg::ST_RST_REC:
         begin
            // reset_high_to_read first, then ready high or the longest ready time
            if (r_ff.cnt >= fprsd_pkg::TRH_CYC - fprsd_pkg::CNT_ONE &&
                (r_ff.rb_s2 || r_ff.cnt >= fprsd_pkg::TREADY_CYC))
            begin
               nxt_r.req_ready = 1'b1;
               nxt_r.state = fprsd_pkg::ST_IDLE;
            end
         end
         default:
         begin
            nxt_r.state = fprsd_pkg::ST_IDLE;
            nxt_r.req_ready = 1'b1;
         end
      endcase
   end

   // state register; power-up starts with a flash reset pulse
   always_ff @(posedge mclk or negedge srst_n)
   begin
      if (!srst_n)
      begin
         r_ff <= '0;
         r_ff.state <= fprsd_pkg::ST_RST_LOW;
         r_ff.ce_n <= 1'b1;
         r_ff.oe_n <= 1'b1;
         r_ff.we_n <= 1'b1;
         r_ff.rb_s1 <= 1'b1;
         r_ff.rb_s2 <= 1'b1;
      end
      else
         r_ff <= nxt_r;
   end

   // -------------------------------------------------------------
   // outputs, straight from the state register
   // -------------------------------------------------------------
   assign req_ready = r_ff.req_ready;
   assign rsp_valid = r_ff.rsp_valid;
   assign rsp_rdata = r_ff.rsp_rdata;
   assign rsp_sector = r_ff.rsp_sector;
   assign reissue_needed = r_ff.reissue;
   assign flash_ce_n = r_ff.ce_n;
   assign flash_oe_n = r_ff.oe_n;
   assign flash_we_n = r_ff.we_n;
   assign flash_reset_n = r_ff.reset_n;
   assign flash_byte_n = r_ff.reset_n | ~r_ff.reset_n; // word mode, constant high
   assign flash_addr = r_ff.addr;
   assign flash_dq_out = r_ff.dq_out;
   assign flash_dq_oe = r_ff.dq_oe;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!srst_n);

   sequence s_reset_dropped;
      $fell(flash_reset_n);
   endsequence

   sequence s_reset_released;
      $rose(flash_reset_n);
   endsequence

   a_read_after_tce: assert property (rsp_valid |-> r_ff.acc_cnt >= fprsd_pkg::TCE_CYC + fprsd_pkg::SYNC_LAT)
      else $error("read data sampled before access time");
   a_reset_width: assert property (s_reset_released |-> r_ff.rlow_cnt >= fprsd_pkg::TREP_CYC)
      else $error("reset pulse shorter than trep");
   a_reset_quiet: assert property (!flash_reset_n |-> !flash_dq_oe && flash_ce_n && flash_we_n)
      else $error("bus driven during reset");
   a_recovery_gap: assert property ($fell(flash_ce_n) |-> r_ff.since_cnt >= fprsd_pkg::TRH_CYC)
      else $error("access started inside reset_high_to_read");
   a_reissue_flag: assert property (s_reset_dropped ##0 !$past(r_ff.rb_s2) |-> reissue_needed)
      else $error("interrupted operation not flagged");
   a_reset_release: assert property (s_reset_dropped |-> !flash_reset_n [*8])
      else $error("reset released too soon");
   a_write_drive: assert property (flash_dq_oe |-> flash_oe_n)
      else $error("data driven while output gate low");
endmodule : fprsd_host
`default_nettype wire

// file: common/fprsd_pkg.sv
// shared constants and types for the flash reset and sector host controller
`default_nettype none
package fprsd_pkg;
   // -------------------------------------------------------------
   // clock and pin timing
   // -------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int TCE_NS = 70;    // chip-select access time
   localparam int TREP_NS = 500;  // least reset pulse width
   localparam int TRH_NS = 50;    // reset high to first read
   localparam int TWP_NS = 35;    // write strobe low time
   localparam int TREADY_NS = 20000; // longest internal reset
   localparam int CNT_W = 11;
   // least times round up
   localparam logic [CNT_W-1:0] TCE_CYC = CNT_W'((TCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] TREP_CYC = CNT_W'((TREP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] TRH_CYC = CNT_W'((TRH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] TWP_CYC = CNT_W'((TWP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] TREADY_CYC = CNT_W'(TREADY_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] SYNC_LAT = 11'h002;
   localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
   localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
   localparam logic [CNT_W-1:0] CNT_MAX = 11'h7FF;
   // -------------------------------------------------------------
   // bus widths and sector map
   // -------------------------------------------------------------
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam int SECT_W = 6;
   localparam logic [4:0] UPPER_ALL_ONES = 5'h1F;
   localparam logic [SECT_W-1:0] SECTOR_HALF = 6'h1F;      // 32 Kbyte sector 31
   localparam logic [SECT_W-1:0] SECTOR_PARAM_LO = 6'h20;  // 8 Kbyte sector 32
   localparam logic [SECT_W-1:0] SECTOR_PARAM_HI = 6'h21;  // 8 Kbyte sector 33
   localparam logic [SECT_W-1:0] SECTOR_TOP_BOOT = 6'h22;  // 16 Kbyte sector 34
   // -------------------------------------------------------------
   // controller state
   // -------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_RD_WAIT = 7'h02,
      ST_WR_PULSE = 7'h04,
      ST_WR_HOLD = 7'h08,
      ST_RST_LOW = 7'h10,
      ST_RST_REC = 7'h20,
      ST_SPARE = 7'h40
   } fprsd_state_t;

   typedef struct packed {
      fprsd_state_t state;
      logic [CNT_W-1:0] cnt;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic reset_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_out;
      logic dq_oe;
      logic req_ready;
      logic rsp_valid;
      logic [DATA_W-1:0] rsp_rdata;
      logic [SECT_W-1:0] rsp_sector;
      logic reissue;
      logic [DATA_W-1:0] dq_s1;
      logic [DATA_W-1:0] dq_s2;
      logic rb_s1;
      logic rb_s2;
      logic [CNT_W-1:0] acc_cnt;
      logic [CNT_W-1:0] rlow_cnt;
      logic [CNT_W-1:0] since_cnt;
   } fprsd_regs_t;
endpackage : fprsd_pkg
`default_nettype wire

// file: hdl/fprsd_sector_dec.sv
// top-boot sector decoder from upper address bits
`timescale 1ns/1ps
`default_nettype none
module fprsd_sector_dec
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] upper_addr,
   output logic [fprsd_pkg::SECT_W-1:0] sector
);
   // -------------------------------------------------------------
   // decode, purely combinational so it is valid in the same access
   // -------------------------------------------------------------
   always_comb
   begin
      if (upper_addr[7:3] != fprsd_pkg::UPPER_ALL_ONES)
         sector = {1'b0, upper_addr[7:3]};
      else if (!upper_addr[2])
         sector = fprsd_pkg::SECTOR_HALF;
      else if (upper_addr[1])
         sector = fprsd_pkg::SECTOR_TOP_BOOT;
      else if (upper_addr[0])
         sector = fprsd_pkg::SECTOR_PARAM_HI;
      else
         sector = fprsd_pkg::SECTOR_PARAM_LO;
   end

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_uniform_map: assert property (upper_addr[7:3] != 5'h1F |-> sector == {1'b0, upper_addr[7:3]})
      else $error("uniform sector index wrong");
   a_half_sector: assert property (upper_addr[7:2] == 6'h3E |-> sector == 6'h1F)
      else $error("sector 31 not selected");
   a_param_pair: assert property (upper_addr[7:1] == 7'h7E |-> sector == (upper_addr[0] ? 6'h21 : 6'h20))
      else $error("parameter sector wrong");
   a_top_boot: assert property (upper_addr[7:1] == 7'h7F |-> sector == 6'h22)
      else $error("top boot sector wrong");
   a_sector_range: assert property ($stable(upper_addr) |-> sector <= 6'h22 && $stable(sector))
      else $error("sector not a function of address");
endmodule : fprsd_sector_dec
`default_nettype wire

// file: verif/fprsd_flash_model.sv
// behavioural boot-sector flash as seen from its pins
`timescale 1ns/1ps
`default_nettype none
module fprsd_flash_model
#(
   parameter int BUSY_CYC = 40,
   parameter int READY_CYC = 100,
   // the address compare lags one cycle, so 2 here is valid 60 ns after select, inside tce
   parameter int ACC_CYC = 2
)
(
   input wire logic mclk,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic reset_n,
   input wire logic [19:0] addr,
   input wire logic [15:0] wdata,
   output logic [15:0] dq,
   output logic ready_busy_out,
   output logic [15:0] last_wdata
);
   logic [15:0] busy_ff = 16'h0000;
   logic [15:0] acc_ff = 16'h0000;
   logic [15:0] hist_ff = 16'hA5A5;
   logic [15:0] wdata_ff = 16'h0000;
   logic we_q_ff = 1'b1;
   logic [19:0] addr_q_ff = 20'h00000;
   // -------------------------------------------------------------
   // program timer and access counter
   // -------------------------------------------------------------
   // busy runs on when deselected; a reset while busy stretches it
   always_ff @(posedge mclk)
   begin
      we_q_ff <= we_n;
      addr_q_ff <= addr;
      hist_ff <= dq;
      if (!reset_n)
      begin
         if (busy_ff != 16'h0000)
            busy_ff <= 16'(READY_CYC);
      end
      else if (!ce_n && !we_n && we_q_ff)
      begin
         wdata_ff <= wdata;
         busy_ff <= 16'(BUSY_CYC);
      end
      else if (busy_ff != 16'h0000)
         busy_ff <= busy_ff - 16'h0001;
      // reset, select or gate high, or an address change restarts access timing
      if (!reset_n || ce_n || oe_n || addr != addr_q_ff)
         acc_ff <= 16'h0000;
      else if (acc_ff != 16'hFFFF)
         acc_ff <= acc_ff + 16'h0001;
   end
   // -------------------------------------------------------------
   // pins
   // -------------------------------------------------------------
   // undriven bus shows the inverse of its last level, no pull
   assign dq = (reset_n && !ce_n && !oe_n && acc_ff >= 16'(ACC_CYC)) ? (addr[15:0] ^ 16'h5A3C) : ~hist_ff;
   assign ready_busy_out = (busy_ff == 16'h0000);
   assign last_wdata = wdata_ff;
endmodule : fprsd_flash_model
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic mclk, rst_n, req_valid, req_write, reset_req;
   logic [fprsd_pkg::ADDR_W-1:0] req_addr, flash_addr;
   logic [fprsd_pkg::DATA_W-1:0] req_wdata, rsp_rdata, flash_dq_out, dev_dq, last_wdata, dq_in;
   logic [fprsd_pkg::SECT_W-1:0] rsp_sector;
   logic req_ready, rsp_valid, reissue_needed, ce_n, oe_n, we_n, frst_n, dq_oe, ready_busy_out, byte_n;
   int n_errors = 0;
   int checks_done = 0;
   localparam logic [19:0] A_TAB [12] = '{20'h00000, 20'h07FFF, 20'h08000, 20'h80000, 20'hF7FFF, 20'hF8000,
      20'hFBFFF, 20'hFC000, 20'hFCFFF, 20'hFD000, 20'hFE000, 20'hFFFFF};
   localparam logic [5:0] S_TAB [12] = '{6'h00, 6'h00, 6'h01, 6'h10, 6'h1E, 6'h1F,
      6'h1F, 6'h20, 6'h20, 6'h21, 6'h22, 6'h22};
   fprsd_host DUT (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .req_wdata(req_wdata), .reset_req(reset_req), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_sector(rsp_sector), .reissue_needed(reissue_needed),
      .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_reset_n(frst_n), .flash_byte_n(byte_n),
      .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in),
      .ready_busy_out(ready_busy_out));
   fprsd_flash_model flash (.mclk(mclk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(frst_n),
      .addr(flash_addr), .wdata(flash_dq_out), .dq(dev_dq), .ready_busy_out(ready_busy_out),
      .last_wdata(last_wdata));
   // the host's drive wins the shared data wire when enabled
   assign dq_in = dq_oe ? flash_dq_out : dev_dq;
   // -------------------------------------------------------------
   // shared tasks
   // -------------------------------------------------------------
   task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] got);
      checks_done++;
      if (got !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
         n_errors++;
      end
   endtask : chk
   // wait for idle, then hold the request over the accepting edge
   task automatic send(input logic rst, input logic wr, input logic [19:0] a, input logic [15:0] d);
      int i;
      i = 0;
      do
      begin
         @(negedge mclk);
         i++;
      end
      while (req_ready !== 1'b1 && i < 2000);
      chk("request ready", 20'h00001, {19'h0, req_ready});
      @(posedge mclk);
      reset_req <= rst;
      req_valid <= !rst;
      req_write <= wr;
      req_addr <= a;
      req_wdata <= d;
      @(posedge mclk);
      reset_req <= 1'b0;
      req_valid <= 1'b0;
   endtask : send
   task automatic test_read(input logic [19:0] a, input logic [5:0] sec);
      int n;
      n = 0;
      send(1'b0, 1'b0, a, 16'h0000);
      do
      begin
         @(negedge mclk);
         n++;
      end
      while (rsp_valid !== 1'b1 && n < 50);
      chk("read strobe", 20'h00001, {19'h0, rsp_valid});
      chk("word mode", 20'h00001, {19'h0, byte_n});
      chk("read data", {4'h0, a[15:0] ^ 16'h5A3C}, {4'h0, rsp_rdata});
      chk("sector", {14'h0, sec}, {14'h0, rsp_sector});
      chk("read wait", 20'(n >= int'(fprsd_pkg::TCE_CYC)), 20'h00001);
   endtask : test_read
   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   // boundaries of every sector class of the top-boot map
   task automatic test_sectors();
      for (int k = 0; k < 12; k++)
         test_read(A_TAB[k], S_TAB[k]);
      $display("test sectors done");
   endtask : test_sectors
   // reset pulse, recovery wait, reissue flag, array read afterwards
   task automatic test_reset(input logic busy);
      int lo, rec;
      lo = 0;
      rec = 0;
      // an earlier program must be over, else the reset counts as interrupting it
      while (!busy && ready_busy_out !== 1'b1 && rec < 2000)
      begin
         @(negedge mclk);
         rec++;
      end
      rec = 0;
      repeat (3) @(negedge mclk);
      if (busy)
         send(1'b0, 1'b1, 20'hFE123, 16'hC3A5);
      send(1'b1, 1'b0, 20'h00000, 16'h0000);
      // the pin only drops after the accepting edge has settled
      @(negedge mclk);
      while (frst_n !== 1'b1 && lo < 2000)
      begin
         @(negedge mclk);
         lo++;
      end
      while (req_ready !== 1'b1 && rec < 2000)
      begin
         @(negedge mclk);
         rec++;
      end
      chk("reset low", 20'(lo >= int'(fprsd_pkg::TREP_CYC) && lo < 2000), 20'h00001);
      chk("recovery", 20'(rec >= int'(fprsd_pkg::TRH_CYC) && rec < 2000), 20'h00001);
      chk("reissue flag", {19'h0, busy}, {19'h0, reissue_needed});
      if (busy)
      begin
         chk("program word", 20'h0C3A5, {4'h0, last_wdata});
         send(1'b0, 1'b1, 20'hFE123, 16'hC3A5);
         @(negedge mclk);
         chk("reissue clear", 20'h00000, {19'h0, reissue_needed});
      end
      test_read(20'hFD0F0, 6'h21);
      $display("test reset busy=%0d done", busy);
   endtask : test_reset
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run
   // -------------------------------------------------------------
   // clock, sequence and watchdog
   // -------------------------------------------------------------
   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   initial
   begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_write = 1'b0;
      reset_req = 1'b0;
      req_addr = 20'h00000;
      req_wdata = 16'h0000;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      test_sectors();
      test_reset(1'b1);
      test_reset(1'b0);
      complete_run();
   end
   // all tests need a few hundred cycles
   initial
   begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
